/* File: core/ihcd_regs.svh */
`ifndef IHCD_REGS_SVH
`define IHCD_REGS_SVH

// Register offsets (CSR index)
`define IHCD_OFS_DATA_PORT     5'h10
`define IHCD_OFS_HOLE          5'h11
`define IHCD_OFS_LOW_ONLY      5'h1e
`define IHCD_OFS_RESET         5'h1f
`define IHCD_OFS_POWER_MGMT    5'h0b
`define IHCD_REG_COUNT         32
// Power management register layout
`define IHCD_PMR_STANDBY_BIT   4
`define IHCD_PMR_RESET_VALUE   8'h10
// Host address window edges
`define IHCD_CSR_SPAN          12'h040
// Data FIFO
`define IHCD_FIFO_WIDTH        16
`define IHCD_FIFO_DEPTH        8
// Reset pulse length after a read of the reset offset, cycles
`define IHCD_RESET_PULSE       4'h4

`endif

/* File: core/ihcd_pkg.sv */
package ihcd_pkg;
  typedef logic [7:0]  ihcd_byte_t;
  typedef logic [15:0] ihcd_word_t;
  typedef enum logic [1:0] {
    IHCD_ACC_CSR,
    IHCD_ACC_PIO,
    IHCD_ACC_WINDOW,
    IHCD_ACC_NONE
  } ihcd_acc_e;
endpackage

/* File: core/ihcd_fifo.sv */
`timescale 1ns/10ps
module ihcd_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clock_in,
  input  wire logic             sys_rst_in,
  // Fill side
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // Drain side
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  assign in_ready_out  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid_out = (count_reg != '0);
  assign out_data_out  = mem_reg[rd_ptr_reg];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  always_ff @(posedge clock_in) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_in;
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule

/* File: core/ihcd_decode.sv */
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/10ps
`include "ihcd_regs.svh"
// Summary of operation
// - ISA mode when both EEPROM straps unpulled
// - Register n sits at host address 2n
// - Even read gives n+1 high, n low
// - Register writes store low lane only
// - Offset 1E read refreshes low lane only; upper lane holds old byte
// - Offset 1F read resets; write stores
// - PIO data port at offset 10h
// - Window select access reaches SRAM-like port
// - Single transfers on both data ports
// - Burst reads stream successive packet words
// - Standby bit zero disables core regulator
module ihcd_decode (
  // Clock and reset
  input  wire logic        clock_in,
  input  wire logic        sys_rst_in,
  // Straps (pins)
  input  wire logic        eeprom_chip_select_strap_in,
  input  wire logic        eeprom_clock_strap_in,
  // Host register port
  input  wire logic [11:0] host_addr_in,
  input  wire logic        fifo_window_select_in,
  input  wire logic [15:0] host_data_lanes_in,
  input  wire logic        host_wr_in,
  input  wire logic        host_rd_in,
  output logic      [15:0] host_data_lanes_out,
  output logic             host_data_lanes_oe_n_out,
  // Packet receive stream into the device
  input  wire logic        rx_valid_in,
  output logic             rx_ready_out,
  input  wire logic [15:0] rx_data_in,
  // Packet transmit stream out of the device
  output logic             tx_valid_out,
  output logic      [15:0] tx_data_out,
  // Status and control
  output logic             isa_mode_out,
  output logic             soft_reset_out,
  output logic             regulator_enable_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Strap capture: two flops then latch once after reset release

  logic [1:0] strap_meta_reg;
  logic [1:0] strap_sync_reg;
  logic       strap_taken_reg;
  logic       isa_mode_reg;

  always_ff @(posedge clock_in) begin
    strap_meta_reg <= {eeprom_chip_select_strap_in, eeprom_clock_strap_in};
    strap_sync_reg <= strap_meta_reg;
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      strap_taken_reg <= 1'b0;
      isa_mode_reg    <= 1'b0;
    end else if (!strap_taken_reg) begin
      strap_taken_reg <= 1'b1;
      isa_mode_reg    <= (strap_sync_reg == 2'b00);
    end
  end

  assign isa_mode_out = isa_mode_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  logic [4:0]          csr_index;
  logic                csr_odd;
  ihcd_pkg::ihcd_acc_e acc_kind;

  logic                in_csr_span;
  logic                hits_data_port;
  logic                hits_hole;

  // Bit 0 of the host address never reaches the register select
  assign csr_index      = host_addr_in[5:1];
  assign in_csr_span    = (host_addr_in < `IHCD_CSR_SPAN);
  assign hits_data_port = (csr_index == `IHCD_OFS_DATA_PORT);
  assign hits_hole      = (csr_index == `IHCD_OFS_HOLE);

  always_comb begin
    csr_odd = csr_index[0];
    if (fifo_window_select_in) begin
      acc_kind = ihcd_pkg::IHCD_ACC_WINDOW;
    end else if (!in_csr_span) begin
      acc_kind = ihcd_pkg::IHCD_ACC_NONE;
    end else if (hits_data_port) begin
      acc_kind = ihcd_pkg::IHCD_ACC_PIO;
    end else if (hits_hole) begin
      acc_kind = ihcd_pkg::IHCD_ACC_NONE;
    end else begin
      acc_kind = ihcd_pkg::IHCD_ACC_CSR;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file, byte wide

  ihcd_pkg::ihcd_byte_t csr_reg [`IHCD_REG_COUNT];
  logic                 csr_wr;

  // Only plain register slots take writes; data port and hole are excluded
  assign csr_wr = host_wr_in && (acc_kind == ihcd_pkg::IHCD_ACC_CSR);

  genvar gi;
  generate
    for (gi = 0; gi < `IHCD_REG_COUNT; gi++) begin : g_csr
      always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
          csr_reg[gi] <= (gi == `IHCD_OFS_POWER_MGMT) ? `IHCD_PMR_RESET_VALUE : 8'h00;
        end else if (csr_wr && csr_index == 5'(gi)) begin
          csr_reg[gi] <= host_data_lanes_in[7:0];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Packet data: receive FIFO feeds reads of either data port

  logic        fifo_valid;
  logic        fifo_pop;
  logic [15:0] fifo_data;
  logic        data_rd;
  logic        data_wr;

  assign data_rd  = host_rd_in && (acc_kind == ihcd_pkg::IHCD_ACC_PIO
                                   || acc_kind == ihcd_pkg::IHCD_ACC_WINDOW);
  assign data_wr  = host_wr_in && (acc_kind == ihcd_pkg::IHCD_ACC_PIO
                                   || acc_kind == ihcd_pkg::IHCD_ACC_WINDOW);
  // Each read of a non-empty FIFO pops one word; the window address value is ignored so bursts stream
  assign fifo_pop = data_rd;

  ihcd_fifo #(
    .WIDTH (`IHCD_FIFO_WIDTH),
    .DEPTH (`IHCD_FIFO_DEPTH)
  ) u_rx_fifo (
    .clock_in      (clock_in),
    .sys_rst_in    (sys_rst_in),
    .in_valid_in   (rx_valid_in),
    .in_ready_out  (rx_ready_out),
    .in_data_in    (rx_data_in),
    .out_valid_out (fifo_valid),
    .out_ready_in  (fifo_pop),
    .out_data_out  (fifo_data)
  );

  // One pulse per data-port write
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      tx_valid_out <= 1'b0;
    end else begin
      tx_valid_out <= data_wr;
    end
  end

  // Packet data leaves as a whole word, both lanes
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      tx_data_out <= 16'h0000;
    end else if (data_wr) begin
      tx_data_out <= host_data_lanes_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data path
  // Each candidate word is formed on its own so the steering mux stays flat

  ihcd_pkg::ihcd_byte_t csr_lo_byte;
  ihcd_pkg::ihcd_byte_t csr_hi_byte;
  ihcd_pkg::ihcd_word_t csr_even_word;
  ihcd_pkg::ihcd_word_t csr_odd_word;
  ihcd_pkg::ihcd_word_t csr_low_word;
  ihcd_pkg::ihcd_word_t data_word;
  logic                 is_low_only;
  logic                 is_reset_ofs;
  ihcd_pkg::ihcd_word_t rd_word;
  logic                 rd_drive_hi;
  logic                 rd_drive_lo;

  assign csr_lo_byte   = csr_reg[csr_index];
  assign csr_hi_byte   = csr_reg[csr_index + 5'h01];
  assign csr_even_word = {csr_hi_byte, csr_lo_byte};
  assign csr_odd_word  = {csr_lo_byte, csr_lo_byte};
  assign csr_low_word  = {8'h00, csr_lo_byte};
  // An empty FIFO reads as zero and pops nothing
  assign data_word     = fifo_valid ? fifo_data : 16'h0000;
  assign is_low_only   = (csr_index == `IHCD_OFS_LOW_ONLY);
  assign is_reset_ofs  = (csr_index == `IHCD_OFS_RESET);

  always_comb begin
    rd_word     = 16'h0000;
    rd_drive_hi = 1'b0;
    rd_drive_lo = 1'b0;
    case (acc_kind)
      ihcd_pkg::IHCD_ACC_CSR: begin
        if (is_low_only) begin
          rd_word     = csr_low_word;
          rd_drive_lo = 1'b1;
          rd_drive_hi = 1'b0;
        end else if (is_reset_ofs) begin
          rd_word     = 16'h0000;
          rd_drive_lo = 1'b0;
          rd_drive_hi = 1'b0;
        end else if (csr_odd) begin
          rd_word     = csr_odd_word;
          rd_drive_lo = 1'b1;
          rd_drive_hi = 1'b1;
        end else begin
          rd_word     = csr_even_word;
          rd_drive_lo = 1'b1;
          rd_drive_hi = 1'b1;
        end
      end
      ihcd_pkg::IHCD_ACC_PIO: begin
        rd_word     = data_word;
        rd_drive_lo = 1'b1;
        rd_drive_hi = 1'b1;
      end
      ihcd_pkg::IHCD_ACC_WINDOW: begin
        rd_word     = data_word;
        rd_drive_lo = 1'b1;
        rd_drive_hi = 1'b1;
      end
      default: begin
        rd_word     = 16'h0000;
        rd_drive_lo = 1'b0;
        rd_drive_hi = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lane output: output enable low means drive

  ihcd_pkg::ihcd_byte_t lane_lo_reg;
  ihcd_pkg::ihcd_byte_t lane_hi_reg;
  logic                 lane_oe_n_reg;

  // Lower lane clears when a read leaves it undriven
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      lane_lo_reg <= 8'h00;
    end else if (host_rd_in) begin
      lane_lo_reg <= rd_drive_lo ? rd_word[7:0] : 8'h00;
    end
  end

  // Upper lane keeps its old value when a read leaves it undriven
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      lane_hi_reg <= 8'h00;
    end else if (host_rd_in && rd_drive_hi) begin
      lane_hi_reg <= rd_word[15:8];
    end
  end

  // Drive for exactly the cycle after a read that returns data
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      lane_oe_n_reg <= 1'b1;
    end else if (host_rd_in) begin
      lane_oe_n_reg <= !(rd_drive_lo || rd_drive_hi);
    end else begin
      lane_oe_n_reg <= 1'b1;
    end
  end

  assign host_data_lanes_out      = {lane_hi_reg, lane_lo_reg};
  assign host_data_lanes_oe_n_out = lane_oe_n_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Soft reset pulse on read of the reset offset

  logic [3:0] reset_cnt_reg;
  logic       reset_hit;

  assign reset_hit = host_rd_in && (acc_kind == ihcd_pkg::IHCD_ACC_CSR) && is_reset_ofs;

  // A fresh hit restarts the count so back-to-back reads stretch the pulse
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      reset_cnt_reg <= 4'h0;
    end else if (reset_hit) begin
      reset_cnt_reg <= `IHCD_RESET_PULSE;
    end else if (reset_cnt_reg > 4'h1) begin
      reset_cnt_reg <= reset_cnt_reg - 4'h1;
    end else begin
      reset_cnt_reg <= 4'h0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      soft_reset_out <= 1'b0;
    end else begin
      soft_reset_out <= reset_hit || (reset_cnt_reg > 4'h1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Regulator control

  logic standby_bit;

  // A zero in the standby bit turns the core regulator off
  assign standby_bit = csr_reg[`IHCD_OFS_POWER_MGMT][`IHCD_PMR_STANDBY_BIT];

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      regulator_enable_out <= 1'b1;
    end else begin
      regulator_enable_out <= standby_bit;
    end
  end

endmodule

/* File: verification/ihcd_decode_props.sv */
`timescale 1ns/10ps
module ihcd_decode_props (
  // Clock, reset and host strobes
  input wire logic        clock_in,
  input wire logic        sys_rst_in,
  input wire logic [11:0] host_addr_in,
  input wire logic        fifo_window_select_in,
  input wire logic [15:0] host_data_lanes_in,
  input wire logic        host_wr_in,
  input wire logic        host_rd_in,
  // Device answers
  input wire logic [15:0] host_data_lanes_out,
  input wire logic        host_data_lanes_oe_n_out,
  input wire logic        tx_valid_out,
  input wire logic [15:0] tx_data_out,
  input wire logic        soft_reset_out,
  input wire logic        regulator_enable_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  logic       csr;
  logic [4:0] idx;
  assign csr = !fifo_window_select_in && host_addr_in < 12'h040;
  assign idx = host_addr_in[5:1];
  chk_window_read: assert property (
    host_rd_in && fifo_window_select_in |=> !host_data_lanes_oe_n_out)
    else $error("window read not driven");
  chk_odd_mirror: assert property (
    host_rd_in && csr && idx[0] && idx != 5'h11 && idx != 5'h1f
    |=> !host_data_lanes_oe_n_out && host_data_lanes_out[15:8] == host_data_lanes_out[7:0])
    else $error("odd read lanes differ");
  chk_upper_hold: assert property (
    host_rd_in && csr && idx == 5'h1e |=> $stable(host_data_lanes_out[15:8]))
    else $error("upper lane moved");
  chk_reset_read: assert property (
    host_rd_in && csr && idx == 5'h1f |=> host_data_lanes_oe_n_out ##[0:4] soft_reset_out)
    else $error("reset read wrong");
  chk_unused_quiet: assert property (
    host_rd_in && !fifo_window_select_in && host_addr_in >= 12'h040 |=> host_data_lanes_oe_n_out)
    else $error("unused read driven");
  chk_data_tx: assert property (
    host_wr_in && (fifo_window_select_in || csr && idx == 5'h10)
    |=> tx_valid_out && tx_data_out == $past(host_data_lanes_in))
    else $error("data write not sent");
  chk_csr_no_tx: assert property (
    host_wr_in && csr && idx != 5'h10 |=> !tx_valid_out)
    else $error("register write sent");
  chk_standby_off: assert property (
    host_wr_in && csr && idx == 5'h0b && !host_data_lanes_in[4] |-> ##[1:2] !regulator_enable_out)
    else $error("regulator still on");
endmodule
bind ihcd_decode ihcd_decode_props chk_u (.*);

/* File: verification/ihcd_host_model.sv */
`timescale 1ns/10ps
module ihcd_host_model (
  // Clock
  input  wire logic        clock_in,
  // Host bus
  output logic      [11:0] addr_out,
  output logic             win_out,
  output logic      [15:0] data_out,
  output logic             wr_out,
  output logic             rd_out,
  input  wire logic [15:0] lanes_in,
  input  wire logic        oe_n_in
);
  assign win_out = addr_out[11];
  initial begin
    addr_out = 12'h7fe;
    data_out = 16'h0;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end
  // Single write; data lines turned over once released
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge clock_in);
    addr_out <= a;
    data_out <= d;
    wr_out   <= 1'b1;
    @(posedge clock_in);
    wr_out   <= 1'b0;
    data_out <= ~d;
  endtask
  task automatic rd(input logic [11:0] a, output logic [15:0] d, output logic z);
    @(posedge clock_in);
    addr_out <= a;
    rd_out   <= 1'b1;
    @(posedge clock_in);
    rd_out   <= 1'b0;
    // Answer is launched on this edge; look once it has settled
    #1;
    d = lanes_in;
    z = oe_n_in;
  endtask
endmodule

/* File: verification/isa_mode_host_csr_decode_test.sv */
`timescale 1ns/10ps
module isa_mode_host_csr_decode_test;
  logic        clock_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic        eeprom_chip_select_strap_in = 1'b1;
  logic        eeprom_clock_strap_in = 1'b0;
  logic        rx_valid_in = 1'b0;
  logic [15:0] rx_data_in = 16'h0;
  logic [11:0] host_addr_in;
  logic [15:0] host_data_lanes_in, host_data_lanes_out, tx_data_out, got, last_tx;
  logic        fifo_window_select_in, host_wr_in, host_rd_in, host_data_lanes_oe_n_out;
  logic        rx_ready_out, tx_valid_out, isa_mode_out, soft_reset_out, regulator_enable_out;
  logic        z, hit;
  logic [7:0]  rv [32];
  int          bad_count = 0;
  int          samples_checked = 0;
  int          tx_cnt = 0;
  int          cyc = 0;
  always #20 clock_in = ~clock_in;
  ihcd_host_model host_u (
    .clock_in (clock_in),
    .addr_out (host_addr_in),
    .win_out  (fifo_window_select_in),
    .data_out (host_data_lanes_in),
    .wr_out   (host_wr_in),
    .rd_out   (host_rd_in),
    .lanes_in (host_data_lanes_out),
    .oe_n_in  (host_data_lanes_oe_n_out)
  );
  ihcd_decode dut_u (.*);
  ////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d errors %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (tx_valid_out) begin
      tx_cnt  <= tx_cnt + 1;
      last_tx <= tx_data_out;
    end
    if (cyc == 3000) begin
      bad_count++;
      stop_test();
    end
  end
  task automatic do_reset();
    sys_rst_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    repeat (4) @(posedge clock_in);
  endtask
  task automatic push(input logic [15:0] w);
    @(posedge clock_in);
    rx_valid_in <= 1'b1;
    rx_data_in  <= w;
    @(posedge clock_in);
    while (!rx_ready_out) @(posedge clock_in);
    rx_valid_in <= 1'b0;
    rx_data_in  <= ~w;
  endtask
  ////////////////////////////////////////
  task automatic t_mode();
    chk({15'h0, isa_mode_out}, 16'h0);
    eeprom_chip_select_strap_in <= 1'b0;
    do_reset();
    chk({15'h0, isa_mode_out}, 16'h1);
  endtask
  task automatic t_csr();
    for (int n = 0; n < 31; n++) begin
      rv[n] = 8'(n * 7 + 3);
      if (n != 16 && n != 17) host_u.wr(12'(2 * n), {8'hff, rv[n]});
    end
    for (int n = 0; n < 30; n++) begin
      if (n == 16 || n == 17) continue;
      host_u.rd(12'(2 * n), got, z);
      chk(got, {rv[n | 1], rv[n]});
    end
    host_u.rd(12'h03c, got, z);
    chk(got, {rv[29], rv[30]});
  endtask
  task automatic t_unused();
    host_u.wr(12'h040, 16'h00a5);
    host_u.wr(12'h7c2, 16'h005a);
    host_u.rd(12'h040, got, z);
    chk({15'h0, z}, 16'h1);
    host_u.rd(12'h022, got, z);
    chk({15'h0, z}, 16'h1);
    host_u.rd(12'h000, got, z);
    chk(got, {rv[1], rv[0]});
  endtask
  task automatic t_data();
    int c;
    c = tx_cnt;
    host_u.wr(12'h020, 16'hbeef);
    host_u.wr(12'h9a4, 16'h1234);
    repeat (2) @(posedge clock_in);
    chk(last_tx, 16'h1234);
    chk(16'(tx_cnt - c), 16'h2);
    for (int i = 0; i < 8; i++) push(16'(16'hc000 + i));
    @(posedge clock_in);
    chk({15'h0, rx_ready_out}, 16'h0);
    host_u.rd(12'h020, got, z);
    chk(got, 16'hc000);
    for (int i = 1; i < 8; i++) begin
      host_u.rd(12'(12'h800 + 2 * i), got, z);
      chk(got, 16'(16'hc000 + i));
    end
    host_u.rd(12'hffe, got, z);
    chk(got, 16'h0);
  endtask
  task automatic t_reg();
    host_u.wr(12'h016, 16'hffef);
    repeat (2) @(posedge clock_in);
    chk({15'h0, regulator_enable_out}, 16'h0);
    host_u.wr(12'h016, 16'h0010);
    repeat (2) @(posedge clock_in);
    chk({15'h0, regulator_enable_out}, 16'h1);
  endtask
  task automatic t_soft();
    hit = 1'b0;
    host_u.rd(12'h03e, got, z);
    chk({15'h0, z}, 16'h1);
    for (int i = 0; i < 6; i++) begin
      hit = hit | soft_reset_out;
      @(posedge clock_in);
    end
    chk({15'h0, hit}, 16'h1);
  endtask
  initial begin
    do_reset();
    t_mode();
    t_csr();
    t_unused();
    t_data();
    t_reg();
    t_soft();
    stop_test();
  end
endmodule
